// [design/store_map.svh]
// Constants for the octal storage register: widths, reset values, latency.
// Assumes inclusion by bare name from design and test files.
`ifndef STORE_MAP_SVH
`define STORE_MAP_SVH

// Bits held by the register
`define STORE_WIDTH 8
// Stored value and pin filter state after reset
`define HELD_RESET 8'h00
`define PIN_RESET 1'b0
// Output-disable pin idles high, so outputs float out of reset
`define DISABLE_RESET 1'b1
// Output enable levels
`define DRIVE_ON 1'b1
`define DRIVE_OFF 1'b0
// Stages in each pin synchroniser, ahead of its agreement filter flop
`define SYNC_STAGES 3

`endif

// [design/store_pkg.sv]
// Types shared by the octal storage register.
// Assumes store_map.svh is on the include path.
`include "store_map.svh"

package store_pkg;

  // Build-time storage style
  typedef enum logic {
    STYLE_LATCH,
    STYLE_EDGE
  } store_style_e;

  typedef logic [`STORE_WIDTH-1:0] byte_t;

  // Pin group as seen after the synchronisers
  typedef struct packed {
    logic output_disable_n;
    logic gate;
    byte_t data;
  } pin_bundle_s;

  // Three-state output pair
  typedef struct packed {
    byte_t value;
    byte_t drive_en;
  } bus_drive_s;

endpackage : store_pkg

// [design/pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`include "store_map.svh"

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Pins and filtered levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  // First stage feeds only the second
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
      stage3_r <= RESET_VAL;
    end else begin
      stage1_r <= pin_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A bit moves only when stages two and three agree
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= RESET_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_o[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule : pin_sync

// [design/octal_store.sv]
// Octal storage register with three-state outputs, latch or edge style.
// Assumes data, gate and disable arrive asynchronously on pins and that
// the surrounding pad ring resolves value and enable into a bus wire.
`timescale 1ns/1ps
`include "store_map.svh"

module octal_store
  import store_pkg::*;
#(
  parameter store_style_e STYLE = STYLE_LATCH,
  parameter int WIDTH = `STORE_WIDTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Data and control pins
  input wire logic [WIDTH-1:0] data_i,
  input wire logic gate_i,
  input wire logic output_disable_n_i,
  // Three-state output pins
  output logic [WIDTH-1:0] held_value_o,
  output logic [WIDTH-1:0] drive_en_o
);

  localparam logic [WIDTH-1:0] HELD_INIT = WIDTH'(`HELD_RESET);
  localparam logic [WIDTH+1:0] PIN_INIT =
    {`DISABLE_RESET, `PIN_RESET, WIDTH'(`HELD_RESET)};

  logic [WIDTH+1:0] pins_raw;
  logic [WIDTH+1:0] pins_sync;
  logic [WIDTH-1:0] data_f;
  logic gate_f;
  logic disable_f;
  logic gate_prev_r;
  logic gate_rise;
  logic load_en;
  logic [WIDTH-1:0] held_r;
  logic [WIDTH-1:0] held_nxt;
  logic [WIDTH-1:0] drive_nxt;

  // All pins share one synchroniser so their relative timing is kept
  assign pins_raw = {output_disable_n_i, gate_i, data_i};

  pin_sync #(
    .W(WIDTH + 2),
    .RESET_VAL(PIN_INIT)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i(pins_raw),
    .level_o(pins_sync)
  );

  assign data_f = pins_sync[WIDTH-1:0];
  assign gate_f = pins_sync[WIDTH];
  assign disable_f = pins_sync[WIDTH+1];

  // Edge detector on the filtered gate, never on a raw stage
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gate_prev_r <= `PIN_RESET;
    end else begin
      gate_prev_r <= gate_f;
    end
  end

  assign gate_rise = gate_f & ~gate_prev_r;

  // Gate pulses sampled on fewer than two clock edges are lost in the pin filter.
  // Latch capture is the last value followed, one filter lag behind the pins.
  // Style picked at build time; one common load enable for all bits
  generate
    if (STYLE == STYLE_LATCH) begin : g_latch
      // Transparent while high, holds the last followed value after the fall
      assign load_en = gate_f;
    end else begin : g_edge
      // Loads only on the rising transition
      assign load_en = gate_rise;
    end
  endgenerate

  // Disable is deliberately absent from the load path
  always_comb begin
    held_nxt = held_r;
    if (load_en) begin
      held_nxt = data_f;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      held_r <= HELD_INIT;
    end else begin
      held_r <= held_nxt;
    end
  end

  // Output value register tracks storage so pins come from a flop
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      held_value_o <= HELD_INIT;
    end else begin
      held_value_o <= held_nxt;
    end
  end

  // One enable per bit; the pad ring floats a bit whose enable is low
  assign drive_nxt = disable_f ? {WIDTH{`DRIVE_OFF}} : {WIDTH{`DRIVE_ON}};

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_en_o <= {WIDTH{`DRIVE_OFF}};
    end else begin
      drive_en_o <= drive_nxt;
    end
  end

  // Checks

  default clocking cb @(posedge mclk_i);
  endclocking

  default disable iff (reset_i);

  // Output pins always mirror storage one cycle after the load decision
  pins_mirror_a: assert property (
    held_value_o == held_r
  ) else $error("output value differs from stored value");

  // All bits move only on the common load decision
  held_change_a: assert property (
    $changed(held_r) |-> $past(load_en)
  ) else $error("stored value changed without a load");

  // A load taken while the outputs float still lands in storage
  disable_blind_a: assert property (
    (load_en && disable_f) |=> (held_r == $past(data_f))
  ) else $error("load lost while outputs floated");

  float_on_disable_a: assert property (
    disable_f |=> (drive_en_o == {WIDTH{`DRIVE_OFF}})
  ) else $error("outputs driven while disable is high");

  drive_on_enable_a: assert property (
    !disable_f |=> (drive_en_o == {WIDTH{`DRIVE_ON}})
  ) else $error("outputs floating while disable is low");

  disable_release_a: assert property (
    $fell(disable_f) |=> $rose(drive_en_o[0]) && (held_value_o == held_r)
  ) else $error("outputs not restored one cycle after disable falls");

  generate
    if (STYLE == STYLE_LATCH) begin : g_latch_chk

      transparent_follow_a: assert property (
        gate_f |=> (held_value_o == $past(data_f))
      ) else $error("latch output does not follow data while gate high");

      latch_hold_a: assert property (
        !gate_f |=> $stable(held_r)
      ) else $error("latch changed while gate low");

      fall_capture_a: assert property (
        $fell(gate_f) ##1 !gate_f [*3] |-> (held_r == $past(data_f, 4))
      ) else $error("latch did not keep data present at gate fall");

      float_still_loads_a: assert property (
        (disable_f && gate_f) |=> (held_r == $past(data_f))
      ) else $error("latch stopped following while outputs floated");

      gate_fall_c: cover property (
        gate_f ##1 !gate_f ##1 (data_f != held_r)
      );

      hidden_load_c: cover property (
        (disable_f && gate_f) ##1 disable_f ##1 !disable_f
      );

    end else begin : g_edge_chk

      rise_load_a: assert property (
        gate_rise |=> (held_value_o == $past(data_f))
      ) else $error("flip-flop did not load on rising transition");

      edge_hold_a: assert property (
        !gate_rise |=> $stable(held_r)
      ) else $error("flip-flop changed without a rising transition");

      high_gate_hold_a: assert property (
        (gate_f && gate_prev_r) [*2] |=> $stable(held_value_o)
      ) else $error("flip-flop followed data while clock high");

      float_edge_load_a: assert property (
        (disable_f && gate_rise) |=> (held_r == $past(data_f))
      ) else $error("flip-flop skipped load while outputs floated");

      rise_new_c: cover property (
        gate_rise && (data_f != held_r)
      );

      hidden_edge_c: cover property (
        (disable_f && gate_rise) ##1 disable_f [*2] ##1 !disable_f
      );

    end
  endgenerate

  disable_toggle_c: cover property (
    !disable_f ##1 disable_f ##1 !disable_f
  );

endmodule : octal_store

// [test/bus_side.sv]
// Bus-side partner: resolves the register's value/enable pair into bus levels.
// Assumes one clock; a released bit shows the inverse of its last driven level,
// so a float never reads back as a stale match.
`timescale 1ns/1ps
`include "store_map.svh"

module bus_side
  import store_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Register drive pair
  input wire bus_drive_s drive_i,
  // Resolved bus
  output byte_t bus_o
);
  byte_t last_r = 8'h00;

  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < `STORE_WIDTH; i++) begin
      if (drive_i.drive_en[i]) begin
        last_r[i] <= drive_i.value[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `STORE_WIDTH; i++) begin
      bus_o[i] = drive_i.drive_en[i] ? drive_i.value[i] : ~last_r[i];
    end
  end
endmodule : bus_side

// [test/testbench.sv]
// Self-checking bench: both storage styles share one set of pins.
// Assumes a fixed five-edge lag from a pin change to the outputs.
`timescale 1ns/1ps

module testbench;
  import store_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  byte_t data_i = 8'h00;
  logic gate_i = 1'b0;
  logic output_disable_n_i = 1'b1;
  byte_t held_l, held_e, en_l, en_e, bus_l, cur, m;
  byte_t q_l[$];
  byte_t q_e[$];
  byte_t q_en[$];
  int mismatches = 0;
  int comparisons = 0;

  always #5 mclk_i = ~mclk_i;

  octal_store #(.STYLE(STYLE_LATCH)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .data_i(data_i), .gate_i(gate_i),
    .output_disable_n_i(output_disable_n_i), .held_value_o(held_l), .drive_en_o(en_l));
  octal_store #(.STYLE(STYLE_EDGE)) dut_edge (
    .mclk_i(mclk_i), .reset_i(reset_i), .data_i(data_i), .gate_i(gate_i),
    .output_disable_n_i(output_disable_n_i), .held_value_o(held_e), .drive_en_o(en_e));
  bus_side side (.mclk_i(mclk_i), .drive_i({held_l, en_l}), .bus_o(bus_l));

  task compare_byte(input byte_t got, input byte_t exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare_byte

  task stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step

  // An unexpected change is compared against its own inverse, so it fails
  always @(held_l) if (!reset_i) begin
    compare_byte(held_l, q_l.size() ? q_l.pop_front() : ~held_l);
  end
  always @(held_e) if (!reset_i) begin
    compare_byte(held_e, q_e.size() ? q_e.pop_front() : ~held_e);
  end
  always @(en_l) if (!reset_i) begin
    #1;
    compare_byte(en_l, q_en.size() ? q_en.pop_front() : ~en_l);
    compare_byte(en_e, en_l);
    if (en_l === 8'hff) compare_byte(bus_l, held_l);
  end

  initial begin
    void'($urandom(32'h7498593f));
    step(3);
    reset_i = 1'b0;
    step(1);
    compare_byte(held_l, 8'h00);
    compare_byte(held_e, 8'h00);
    compare_byte(en_l, 8'h00);
    cur = 8'h00;
    q_en.push_back(8'hff);
    output_disable_n_i = 1'b0;
    step(6);
    for (int k = 0; k < 6; k++) begin
      // Load a value differing from both stored values
      m = byte_t'($urandom) | 8'h01;
      cur ^= m;
      data_i = cur;
      q_l.push_back(cur);
      q_e.push_back(cur);
      step(2);
      gate_i = 1'b1;
      step(6);
      // Data moves while gate stays high: only the latch follows
      m = (byte_t'($urandom) | 8'h02) & 8'hfe;
      cur ^= m;
      data_i = cur;
      q_l.push_back(cur);
      step(6);
      gate_i = 1'b0;
      step(3);
      data_i = cur ^ (byte_t'($urandom) | 8'h01);
      step(6);
      // Storage keeps working whether outputs float or drive
      output_disable_n_i = ~output_disable_n_i;
      q_en.push_back(output_disable_n_i ? 8'h00 : 8'hff);
      step(6);
    end
    for (int i = 0; i < 20 && (q_l.size() + q_e.size() + q_en.size()) > 0; i++) begin
      step(1);
    end
    if ((q_l.size() + q_e.size() + q_en.size()) > 0) begin
      mismatches++;
      $display("BAD %0t expected output changes never came", $time);
    end
    stop_test();
  end
endmodule : testbench
